// *** hdl/bta_consts.vh ***
// Purpose: Constants for the bus transfer attribute block
// Assumes: APB register map, 32-bit words
// Notes:   Transfer types are 5-bit codes, bit 4 first on the bus
`ifndef BTA_CONSTS_VH
`define BTA_CONSTS_VH
// Register byte offsets
`define BTA_OFF_CFG        12'h000
`define BTA_OFF_EAR        12'h004
`define BTA_OFF_SNOOP      12'h008
`define BTA_OFF_STATUS     12'h00C
// Config register fields
`define BTA_CFG_ABE        0
`define BTA_CFG_RST        32'h0000_0000
`define BTA_EAR_RST        32'h0000_0000
// Transfer types
`define BTA_TT_CLEAN       5'b00000
`define BTA_TT_FLUSH       5'b00100
`define BTA_TT_KILL        5'b01100
`define BTA_TT_ECOWX       5'b10100
`define BTA_TT_ECIWX       5'b11100
`define BTA_TT_WWF         5'b00010
`define BTA_TT_WWK         5'b00110
`define BTA_TT_READ        5'b01010
`define BTA_TT_RWITM       5'b01110
`define BTA_TT_WWFA        5'b10010
`define BTA_TT_RATOM       5'b11010
`define BTA_TT_RWITMA      5'b11110
`define BTA_TT_RWNITC      5'b01011
// Transfer codes
`define BTA_TC_DATA        2'b00
`define BTA_TC_TOUCH       2'b01
`define BTA_TC_IFETCH      2'b10
// Size codes
`define BTA_TSIZ_BURST     3'b010
// Snoop actions
`define BTA_ACT_NONE       3'd0
`define BTA_ACT_FLUSH_CAN  3'd1
`define BTA_ACT_KILL_CAN   3'd2
`define BTA_ACT_CLEAN_FL   3'd3
`define BTA_ACT_FLUSH      3'd4
`define BTA_ACT_CLEAN      3'd5
// Master request kinds
`define BTA_REQ_LOAD       3'd0
`define BTA_REQ_STORE      3'd1
`define BTA_REQ_CASTOUT    3'd2
`define BTA_REQ_CACHEOP    3'd3
`define BTA_REQ_ECIWX      3'd4
`define BTA_REQ_ECOWX      3'd5
`define BTA_REQ_STWCX      3'd6
// Cache op kinds
`define BTA_COP_DCBST      2'd0
`define BTA_COP_DCBF       2'd1
`define BTA_COP_DCBZ       2'd2
`define BTA_COP_DCBI       2'd3
`endif

// *** hdl/bta_snoop_decode.v ***
// Purpose: Snoop hit action decode from the snooped transfer type
// Assumes: Inputs synchronous to pclk
// Notes:   Registered outputs, one cycle after the sample
`timescale 1ns/1ps
`include "bta_consts.vh"
module bta_snoop_decode
(
   input  wire       pclk,           // Bus clock
   input  wire       presetn,        // Async reset, low
   input  wire       snp_valid,      // Snooped address strobe
   input  wire       snp_hit,        // Address hits in cache
   input  wire       coherent_in,    // Global input
   input  wire       burst_in,       // Burst indicator input
   input  wire [4:0] snp_type,       // Snooped transfer type
   output reg        act_valid_q,    // Action valid pulse
   output reg  [2:0] act_q,          // Cache action
   output reg        act_single_q    // Snooped transfer was single beat
);

   // ----------------------------------------------------------
   // Action lookup
   // ----------------------------------------------------------
   function [2:0] bta_action;
      input [4:0] tt;
      begin
         case (tt)
            `BTA_TT_WWF,
            `BTA_TT_WWFA:   bta_action = `BTA_ACT_FLUSH_CAN;
            `BTA_TT_WWK,
            `BTA_TT_KILL:   bta_action = `BTA_ACT_KILL_CAN;
            `BTA_TT_READ,
            `BTA_TT_RATOM:  bta_action = `BTA_ACT_CLEAN_FL;
            `BTA_TT_RWITM,
            `BTA_TT_RWITMA: bta_action = `BTA_ACT_FLUSH;
            `BTA_TT_RWNITC: bta_action = `BTA_ACT_CLEAN;
            default:        bta_action = `BTA_ACT_NONE;
         endcase
      end
   endfunction

   // ----------------------------------------------------------
   // Registered decode, only for global transfers
   // ----------------------------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         act_valid_q  <= 1'b0;
         act_q        <= `BTA_ACT_NONE;
         act_single_q <= 1'b0;
      end
      else
      begin
         act_valid_q <= snp_valid & snp_hit & coherent_in;
         if (snp_valid & snp_hit & coherent_in)
         begin
            act_q        <= bta_action(snp_type);
            act_single_q <= ~burst_in;
         end
      end
   end

endmodule // bta_snoop_decode

// *** hdl/bta_top.v ***
// Purpose: Transfer attribute driver and snoop response for the system bus
// Assumes: One bus clock pclk, APB register access, inputs synchronous
// Notes:   Attribute outputs load with the address strobe and hold the tenure
//
// Contract
// - Snoop hit action by transfer type: flush, kill, clean, cancel reservation.
// - With broadcast enabled, cache ops issue clean, flush or kill address-only codes.
// - Single-beat size field: 000 is eight bytes, 001..111 one to seven.
// - Burst indicator only during bursts; burst size field is 010.
// - External control: access register bit 28 on burst, 29..31 on size.
// - Snooper samples burst input to spot single-beat no-cache reads.
// - Read codes 00 data, 01 touch, 10 fetch; writes drive 00.
// - Cache-inhibit asserted for uncached single-beat transfers from page attribute.
// - Cache-inhibit negated for line-allocating burst transfers.
// - Write-through mirrors page attribute on single-beat writes, else negated.
// - Global follows coherence attribute; copy-backs and fetches are nonglobal.
// - Snoop only when the global input is asserted.
// - Output replacement way being reloaded or written out.
// - Attributes drive, change and release with the address bus.
// - Inhibited and write-through stores use write-with-flush.
// - Cast-outs and snoop copy-backs use nonglobal write-with-kill.
`timescale 1ns/1ps
`include "bta_consts.vh"
module bta_top
(
   input  wire        pclk,               // Bus clock 40 MHz
   input  wire        presetn,            // Async reset, low
   // APB slave
   input  wire        psel,               // Slave select
   input  wire        penable,            // Access phase
   input  wire        pwrite,             // Write direction
   input  wire [11:0] paddr,              // Byte address
   input  wire [31:0] pwdata,             // Write data
   output reg  [31:0] prdata,             // Read data
   output reg         pready,             // Ready
   output reg         pslverr,            // Error on unmapped
   // Master request from the core
   input  wire        req_valid,          // Start of address tenure
   input  wire [2:0]  req_kind,           // Request kind
   input  wire [1:0]  req_cop,            // Cache op kind
   input  wire        req_burst,          // Burst transfer
   input  wire [2:0]  req_bytes,          // Byte count, 0 means eight
   input  wire        req_ifetch,         // Instruction fetch
   input  wire        req_touch,          // Touch load
   input  wire        req_snoop_copy,     // Copy-back caused by snoop
   input  wire        attr_inhibit,       // Page inhibit attribute
   input  wire        attr_wthru,         // Page write-through attribute
   input  wire        attr_coherent,      // Page coherence attribute
   input  wire [1:0]  req_way,            // Replacement way
   input  wire        addr_release,       // Address bus released
   // Snooper side
   input  wire        snp_valid,          // Snooped address strobe
   input  wire        snp_hit,            // Address hits in cache
   input  wire        coherent_in,        // Global input
   input  wire        burst_in,           // Burst indicator input
   input  wire [4:0]  snp_type,           // Snooped transfer type
   // Attribute outputs
   output reg         attr_oe,            // Attribute drive enable
   output reg  [4:0]  transfer_type,      // Transfer type
   output reg  [2:0]  transfer_size,      // Transfer size
   output reg         burst_indicator,    // Burst, high active
   output reg  [1:0]  transfer_code,      // Transfer code
   output reg         cache_inhibit_out,  // Cache inhibit, high active
   output reg         write_through_out,  // Write-through, high active
   output reg         coherent_global,    // Global, high active
   output reg  [1:0]  replacement_way,    // Cache way
   output reg         tenure_skip,        // Cache op issued no tenure
   // Snoop action
   output reg         snp_act_valid,      // Action pulse
   output reg  [2:0]  snp_act,            // Action code
   output reg         snp_act_single      // Snooped single-beat
);

   // ----------------------------------------------------------
   // Registers
   // ----------------------------------------------------------
   reg         abe_q;        // address_broadcast_enable
   reg  [31:0] ear_q;        // external_access_reg
   reg  [7:0]  tenure_cnt_q; // Tenures issued
   // Snoop decode results
   wire        act_valid;
   wire [2:0]  act;
   wire        act_single;

   // Completed access strobes
   wire apb_wr = psel & penable & pwrite & pready;
   wire apb_rd = psel & penable & ~pwrite & pready;

   // Offset decode for the four registers
   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `BTA_OFF_CFG) | (a == `BTA_OFF_EAR) |
                  (a == `BTA_OFF_SNOOP) | (a == `BTA_OFF_STATUS);
      end
   endfunction

   // ----------------------------------------------------------
   // APB slave: one wait state, then ready
   // ----------------------------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         abe_q   <= 1'b0;
         ear_q   <= `BTA_EAR_RST;
      end
      else
      begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped(paddr);
         // Writes land only on the completing edge
         if (apb_wr & (paddr == `BTA_OFF_CFG))
            abe_q <= pwdata[`BTA_CFG_ABE];
         if (apb_wr & (paddr == `BTA_OFF_EAR))
            ear_q <= pwdata;
         // Read data loaded in the wait cycle, shown with pready
         if (psel & penable & ~pready & ~pwrite)
         begin
            case (paddr)
               `BTA_OFF_CFG:    prdata <= {31'h0000_0000, abe_q};
               `BTA_OFF_EAR:    prdata <= ear_q;
               `BTA_OFF_SNOOP:  prdata <= {28'h000_0000, act_single, act};
               `BTA_OFF_STATUS: prdata <= {23'h00_0000, attr_oe, tenure_cnt_q};
               default:         prdata <= 32'h0000_0000;
            endcase
         end
         else if (apb_rd)
            prdata <= prdata;
      end
   end

   // ----------------------------------------------------------
   // Next attribute values from the request
   // ----------------------------------------------------------
   reg  [4:0] tt_d;
   reg  [2:0] sz_d;
   reg        bst_d;
   reg  [1:0] tc_d;
   reg        ci_d;
   reg        wt_d;
   reg        gbl_d;
   reg        issue_d;

   always @*
   begin
      tt_d    = `BTA_TT_READ;
      sz_d    = req_bytes;
      bst_d   = 1'b0;
      tc_d    = `BTA_TC_DATA;
      ci_d    = 1'b0;
      wt_d    = 1'b0;
      gbl_d   = attr_coherent;
      issue_d = 1'b1;
      // Defaults give a single-beat data read
      case (req_kind)
         `BTA_REQ_LOAD:
         begin
            bst_d = req_burst;
            tt_d  = req_burst ? `BTA_TT_RWITM : `BTA_TT_READ;
            ci_d  = ~req_burst & attr_inhibit;
            if (req_ifetch)
            begin
               tc_d  = `BTA_TC_IFETCH;
               gbl_d = 1'b0;
            end
            else if (req_touch)
               tc_d = `BTA_TC_TOUCH;
         end
         `BTA_REQ_STORE, `BTA_REQ_STWCX:
         begin
            tt_d = (req_kind == `BTA_REQ_STWCX) ? `BTA_TT_WWFA : `BTA_TT_WWF;
            ci_d = attr_inhibit;
            wt_d = attr_wthru;
         end
         `BTA_REQ_CASTOUT:
         begin
            tt_d  = `BTA_TT_WWK;
            bst_d = 1'b1;
            gbl_d = 1'b0;
         end
         `BTA_REQ_CACHEOP:
         begin
            issue_d = abe_q;
            case (req_cop)
               `BTA_COP_DCBST: tt_d = `BTA_TT_CLEAN;
               `BTA_COP_DCBF:  tt_d = `BTA_TT_FLUSH;
               default:        tt_d = `BTA_TT_KILL;
            endcase
         end
         `BTA_REQ_ECIWX, `BTA_REQ_ECOWX:
         begin
            tt_d  = (req_kind == `BTA_REQ_ECIWX) ? `BTA_TT_ECIWX : `BTA_TT_ECOWX;
            bst_d = ear_q[3];
            sz_d  = ear_q[2:0];
         end
         default:
            issue_d = 1'b0;
      endcase
      // Burst size overrides byte count, except for external control
      if (bst_d & (req_kind != `BTA_REQ_ECIWX) & (req_kind != `BTA_REQ_ECOWX))
         sz_d = `BTA_TSIZ_BURST;
      // Snoop copy-backs never go out global
      if (req_snoop_copy)
         gbl_d = 1'b0;
   end

   // ----------------------------------------------------------
   // Attribute outputs follow the address tenure
   // ----------------------------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         attr_oe           <= 1'b0;
         transfer_type     <= 5'h00;
         transfer_size     <= 3'h0;
         burst_indicator   <= 1'b0;
         transfer_code     <= 2'h0;
         cache_inhibit_out <= 1'b0;
         write_through_out <= 1'b0;
         coherent_global   <= 1'b0;
         replacement_way   <= 2'h0;
         tenure_skip       <= 1'b0;
         tenure_cnt_q      <= 8'h00;
      end
      else
      begin
         // Cache op with broadcast off leaves the bus idle
         tenure_skip <= req_valid & ~issue_d;
         if (req_valid & issue_d)
         begin
            attr_oe           <= 1'b1;
            transfer_type     <= tt_d;
            transfer_size     <= sz_d;
            burst_indicator   <= bst_d;
            transfer_code     <= tc_d;
            cache_inhibit_out <= ci_d;
            write_through_out <= wt_d;
            coherent_global   <= gbl_d;
            replacement_way   <= req_way;
            tenure_cnt_q      <= tenure_cnt_q + 8'h01;
         end
         else if (addr_release)
         begin
            // Tenure ends: stop driving
            attr_oe         <= 1'b0;
            burst_indicator <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------
   // Snoop decode and output registers
   // ----------------------------------------------------------
   bta_snoop_decode u_snoop
   (
      .pclk         (pclk),
      .presetn      (presetn),
      .snp_valid    (snp_valid),
      .snp_hit      (snp_hit),
      .coherent_in  (coherent_in),
      .burst_in     (burst_in),
      .snp_type     (snp_type),
      .act_valid_q  (act_valid),
      .act_q        (act),
      .act_single_q (act_single)
   );

   // Extra stage so actions leave the block from flip-flops
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         snp_act_valid  <= 1'b0;
         snp_act        <= `BTA_ACT_NONE;
         snp_act_single <= 1'b0;
      end
      else
      begin
         snp_act_valid  <= act_valid;
         snp_act        <= act;
         snp_act_single <= act_single;
      end
   end

endmodule // bta_top

// *** tb/bta_bus_agent.sv ***
// Purpose: Bus far side: acknowledge and snooping master
// Assumes: Bench sets ack_wait
// Notes:   Released snoop lines show inverse values, except strobe, hit and global, which go low
`timescale 1ns/1ps
`include "bta_consts.vh"
module bta_bus_agent
(
   input  wire       pclk,            // Clock
   input  wire       presetn,         // Reset
   input  wire       attr_oe,         // Tenure driven
   input  wire [1:0] transfer_code,   // Code
   input  wire [1:0] replacement_way, // Way
   output reg        addr_release,    // Address ack
   output reg        snp_valid,       // Strobe
   output reg        snp_hit,         // Hit
   output reg        coherent_in,     // Global in
   output reg        burst_in,        // Burst in
   output reg  [4:0] snp_type         // Type
);
   integer    ack_wait = 1;
   integer    cnt;
   reg  [1:0] way_seen;
   initial {snp_valid, snp_hit, coherent_in, burst_in, snp_type} = 9'h000;
   // Acknowledge after ack_wait cycles, track the way
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt <= 0;
         addr_release <= 1'b0;
      end
      else if (attr_oe && !addr_release)
      begin
         cnt <= cnt + 1;
         addr_release <= (cnt >= ack_wait);
         if (transfer_code != `BTA_TC_TOUCH)
            way_seen <= replacement_way;
      end
      else
      begin
         cnt <= 0;
         addr_release <= 1'b0;
      end
   // One snoop cycle; global marks coherent traffic
   task snoop(input [4:0] t, input g, input b);
      begin
         @(posedge pclk);
         {snp_valid, snp_hit, coherent_in, burst_in, snp_type} <= {2'b11, g, b, t};
         @(posedge pclk);
         {snp_valid, snp_hit, coherent_in, burst_in, snp_type} <= {3'h0, ~b, ~t};
      end
   endtask
endmodule // bta_bus_agent

// *** tb/bta_checker.sv ***
// Purpose: Attribute and snoop output checks
// Assumes: Only the ports of bta_top are seen
// Notes:   Attributes one edge after request, actions two
`timescale 1ns/1ps
`include "bta_consts.vh"
module bta_checker
(
   input wire       pclk,              // Clock
   input wire       presetn,           // Reset
   input wire       req_valid,         // Start
   input wire [2:0] req_kind,          // Kind
   input wire       req_burst,         // Burst
   input wire [2:0] req_bytes,         // Bytes
   input wire       req_ifetch,        // Fetch
   input wire       attr_inhibit,      // Inhibit
   input wire       attr_wthru,        // Write-through
   input wire       attr_coherent,     // Coherent
   input wire       addr_release,      // Ack
   input wire       snp_valid,         // Strobe
   input wire       snp_hit,           // Hit
   input wire       coherent_in,       // Global in
   input wire       burst_in,          // Burst in
   input wire [4:0] snp_type,          // Snooped type
   input wire       attr_oe,           // Enable
   input wire [4:0] transfer_type,     // Type
   input wire [2:0] transfer_size,     // Size
   input wire       burst_indicator,   // Burst out
   input wire [1:0] transfer_code,     // Code
   input wire       cache_inhibit_out, // Inhibit out
   input wire       write_through_out, // WT out
   input wire       coherent_global,   // Global out
   input wire       snp_act_valid,     // Pulse
   input wire [2:0] snp_act,           // Action
   input wire       snp_act_single     // Single
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Load and taken-snoop strobes
   wire ld = req_valid && req_kind == `BTA_REQ_LOAD;
   wire sn = snp_valid && snp_hit && coherent_in;

   a_single_size:
      assert property (ld && !req_burst && !req_ifetch |=> transfer_size == $past(req_bytes)
         && !burst_indicator && cache_inhibit_out == $past(attr_inhibit)
         && coherent_global == $past(attr_coherent)) else $error("single load attributes");
   a_burst_load:
      assert property (ld && req_burst |=> burst_indicator && !cache_inhibit_out
         && transfer_size == `BTA_TSIZ_BURST) else $error("burst load attributes");
   a_fetch_code:
      assert property (ld && req_ifetch |=> transfer_code == `BTA_TC_IFETCH
         && !coherent_global) else $error("fetch code");
   a_store_flush:
      assert property (req_valid && req_kind == `BTA_REQ_STORE && (attr_inhibit || attr_wthru)
         |=> transfer_code == `BTA_TC_DATA && transfer_type == `BTA_TT_WWF
         && write_through_out == $past(attr_wthru)) else $error("store attributes");
   a_castout_kill:
      assert property (req_valid && req_kind == `BTA_REQ_CASTOUT |=> !coherent_global
         && transfer_type == `BTA_TT_WWK) else $error("castout type");
   a_release_oe:
      assert property (attr_oe && addr_release && !req_valid |=> !attr_oe && !burst_indicator)
         else $error("release");
   a_snoop_kill:
      assert property (sn && snp_type == `BTA_TT_WWK |-> ##2 snp_act_valid
         && snp_act == `BTA_ACT_KILL_CAN) else $error("snoop kill");
   a_snoop_drop:
      assert property (snp_valid && !coherent_in |-> ##2 !snp_act_valid)
         else $error("nonglobal snooped");
   a_single_flag:
      assert property (sn |-> ##2 snp_act_single == !$past(burst_in, 2))
         else $error("single flag");
   a_reserved_none:
      assert property (sn && snp_type == 5'h16 |-> ##2 snp_act == `BTA_ACT_NONE)
         else $error("reserved snoop");
endmodule // bta_checker
bind bta_top bta_checker i_bta_checker (.*);

// *** tb/testbench.sv ***
// Purpose: Scenario bench for bta_top
// Assumes: Bus agent acknowledges tenures
// Notes:   Each task judges its own case
`timescale 1ns/1ps
`include "bta_consts.vh"
module testbench;
   reg         pclk, presetn, psel, penable, pwrite, req_valid, req_burst, req_ifetch, er;
   reg         req_touch, req_snoop_copy, attr_inhibit, attr_wthru, attr_coherent;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [2:0]  req_kind, req_bytes;
   reg  [1:0]  req_cop, req_way;
   wire [31:0] prdata;
   wire        pready, pslverr, addr_release, snp_valid, snp_hit, coherent_in, burst_in;
   wire        attr_oe, burst_indicator, cache_inhibit_out, write_through_out;
   wire        coherent_global, tenure_skip, snp_act_valid, snp_act_single;
   wire [4:0]  snp_type, transfer_type;
   wire [2:0]  transfer_size, snp_act;
   wire [1:0]  transfer_code, replacement_way;
   integer     miscompares, samples_checked, i, n;
   localparam [54:0] SNT = {`BTA_TT_WWF, `BTA_TT_WWK, `BTA_TT_READ, `BTA_TT_RWITM,
      `BTA_TT_WWFA, `BTA_TT_RATOM, `BTA_TT_RWITMA, `BTA_TT_RWNITC, `BTA_TT_CLEAN,
      `BTA_TT_ECOWX, 5'h16};
   localparam [32:0] SNA = {`BTA_ACT_FLUSH_CAN, `BTA_ACT_KILL_CAN, `BTA_ACT_CLEAN_FL,
      `BTA_ACT_FLUSH, `BTA_ACT_FLUSH_CAN, `BTA_ACT_CLEAN_FL, `BTA_ACT_FLUSH, `BTA_ACT_CLEAN,
      `BTA_ACT_NONE, `BTA_ACT_NONE, `BTA_ACT_NONE};
   bta_top i_bta_top (.*);
   bta_bus_agent i_bta_bus_agent (.pclk, .presetn, .attr_oe, .transfer_code, .replacement_way,
      .addr_release, .snp_valid, .snp_hit, .coherent_in, .burst_in, .snp_type);
   // 40 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task print_verdict;
      begin
         $display("compares %0d mismatches %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input ok, input [8*24-1:0] msg);
      begin
         samples_checked = samples_checked + 1;
         if (!ok)
         begin
            $display("[FAIL] %0t ns %0s", $time, msg);
            miscompares = miscompares + 1;
         end
      end
   endtask
   task guard;
      if (n >= 40)
      begin
         chk(1'b0, "wait timed out");
         print_verdict;
      end
   endtask
   task idle;
      begin
         for (n = 0; n < 40 && attr_oe !== 1'b0; n = n + 1)
            @(posedge pclk);
         guard;
      end
   endtask
   // APB transfer held until pready
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         for (n = 0; n < 40 && pready !== 1'b1; n = n + 1)
            @(posedge pclk);
         guard;
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // One tenure request
   task req(input [2:0] k, input [1:0] c, input b, input [2:0] s, input [2:0] f,
      input [2:0] at, input [1:0] w);
      begin
         @(posedge pclk);
         {req_valid, req_kind, req_cop, req_burst, req_bytes} <= {1'b1, k, c, b, s};
         {req_ifetch, req_touch, req_snoop_copy} <= f;
         {attr_inhibit, attr_wthru, attr_coherent, req_way} <= {at, w};
         @(posedge pclk);
         req_valid <= 1'b0;
         #1;
      end
   endtask
   task t_regs;
      begin
         apb(1'b0, `BTA_OFF_CFG, 32'h0000_0000);
         chk(rd === `BTA_CFG_RST && er === 1'b0, "config reset");
         apb(1'b0, `BTA_OFF_EAR, 32'h0000_0000);
         chk(rd === `BTA_EAR_RST, "access reg reset");
         apb(1'b0, 12'h040, 32'h0000_0000);
         chk(rd === 32'h0000_0000 && er === 1'b1, "unmapped");
         $display("regs done");
      end
   endtask
   task t_size;
      for (i = 0; i < 8; i = i + 1)
      begin
         req(`BTA_REQ_LOAD, 2'h0, 1'b0, i[2:0], 3'h0, {i[0], 2'h1}, 2'h0);
         chk(transfer_size === i[2:0] && burst_indicator === 1'b0, "size");
         chk(cache_inhibit_out === i[0] && write_through_out === 1'b0, "inhibit");
         idle;
         if (i == 7)
            $display("size done");
      end
   endtask
   task t_burst;
      begin
         i_bta_bus_agent.ack_wait = 6;
         req(`BTA_REQ_LOAD, 2'h0, 1'b1, 3'h0, 3'h0, 3'h5, 2'h1);
         chk(burst_indicator === 1'b1 && transfer_size === 3'h2, "burst");
         chk(cache_inhibit_out === 1'b0 && replacement_way === 2'h1, "alloc");
         repeat (3) @(posedge pclk);
         #1 chk(attr_oe === 1'b1 && burst_indicator === 1'b1, "held");
         idle;
         chk(burst_indicator === 1'b0, "burst dropped");
         i_bta_bus_agent.ack_wait = 1;
         $display("burst done");
      end
   endtask
   task t_codes;
      begin
         req(`BTA_REQ_LOAD, 2'h0, 1'b0, 3'h4, 3'h2, 3'h1, 2'h0);
         chk(transfer_code === `BTA_TC_TOUCH, "touch");
         idle;
         req(`BTA_REQ_LOAD, 2'h0, 1'b0, 3'h4, 3'h4, 3'h1, 2'h0);
         chk(transfer_code === `BTA_TC_IFETCH && coherent_global === 1'b0, "fetch");
         idle;
         req(`BTA_REQ_LOAD, 2'h0, 1'b0, 3'h4, 3'h0, 3'h1, 2'h0);
         chk(transfer_code === `BTA_TC_DATA && coherent_global === 1'b1, "data");
         idle;
         $display("codes done");
      end
   endtask
   task t_stores;
      begin
         req(`BTA_REQ_STORE, 2'h0, 1'b0, 3'h4, 3'h0, 3'h4, 2'h0);
         chk(transfer_type === `BTA_TT_WWF && write_through_out === 1'b0, "inh store");
         idle;
         req(`BTA_REQ_STORE, 2'h0, 1'b0, 3'h4, 3'h0, 3'h3, 2'h0);
         chk(transfer_type === `BTA_TT_WWF && write_through_out === 1'b1, "wt store");
         idle;
         req(`BTA_REQ_CASTOUT, 2'h0, 1'b1, 3'h0, 3'h1, 3'h1, 2'h3);
         chk(transfer_type === `BTA_TT_WWK && coherent_global === 1'b0, "copy");
         chk(replacement_way === 2'h3, "way");
         idle;
         $display("stores done");
      end
   endtask
   task t_ext;
      begin
         apb(1'b1, `BTA_OFF_EAR, 32'h0000_000B);
         req(`BTA_REQ_ECIWX, 2'h0, 1'b0, 3'h0, 3'h0, 3'h0, 2'h0);
         chk(transfer_type === `BTA_TT_ECIWX && burst_indicator === 1'b1, "ext read");
         chk(transfer_size === 3'h3, "ext read id");
         idle;
         apb(1'b1, `BTA_OFF_EAR, 32'h0000_0004);
         req(`BTA_REQ_ECOWX, 2'h0, 1'b0, 3'h0, 3'h0, 3'h0, 2'h0);
         chk(transfer_type === `BTA_TT_ECOWX && burst_indicator === 1'b0, "ext write");
         chk(transfer_size === 3'h4, "ext write id");
         idle;
         $display("ext done");
      end
   endtask
   task t_cop;
      begin
         req(`BTA_REQ_CACHEOP, `BTA_COP_DCBF, 1'b0, 3'h0, 3'h0, 3'h1, 2'h0);
         chk(tenure_skip === 1'b1 && attr_oe === 1'b0, "no broadcast");
         apb(1'b1, `BTA_OFF_CFG, 32'h0000_0001);
         for (i = 0; i < 4; i = i + 1)
         begin
            req(`BTA_REQ_CACHEOP, i[1:0], 1'b0, 3'h0, 3'h0, 3'h1, 2'h0);
            chk(attr_oe === 1'b1 && transfer_type === ((i == 0) ? `BTA_TT_CLEAN :
               (i == 1) ? `BTA_TT_FLUSH : `BTA_TT_KILL), "cache op code");
            idle;
         end
         $display("cop done");
      end
   endtask
   task act_wait;
      for (n = 0; n < 6 && snp_act_valid !== 1'b1; n = n + 1)
         @(posedge pclk);
   endtask
   task t_snoop;
      begin
         for (i = 0; i < 11; i = i + 1)
         begin
            i_bta_bus_agent.snoop(SNT[(10 - i) * 5 +: 5], 1'b1, i[0]);
            act_wait;
            chk(n < 6 && snp_act === SNA[(10 - i) * 3 +: 3], "snoop action");
            chk(snp_act_single === ~i[0], "single flag");
         end
         i_bta_bus_agent.snoop(`BTA_TT_WWK, 1'b0, 1'b0);
         act_wait;
         chk(n == 6, "nonglobal snooped");
         $display("snoop done");
      end
   endtask
   // Main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, req_valid, req_kind, req_cop, req_burst} = 0;
      {req_bytes, req_ifetch, req_touch, req_snoop_copy, attr_inhibit, attr_wthru} = 0;
      {attr_coherent, req_way, miscompares, samples_checked, presetn} = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_size;
      t_burst;
      t_codes;
      t_stores;
      t_ext;
      t_cop;
      t_snoop;
      print_verdict;
   end
endmodule // testbench
